// *** rtl/tpc_top.sv ***
// Pin B role control for timer channels 1 and 2 with register port
`timescale 1ns/1ns
module tpc_top
    import tpc_pkg::*;
#(
    parameter int CNT_W = tpc_pkg::CNT_W_DEF
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [tpc_pkg::ADDR_W-1:0] addr,
    input wire logic [tpc_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [tpc_pkg::DATA_W-1:0] rdata,
    input wire logic [CNT_W-1:0] ch1_count,
    input wire logic [CNT_W-1:0] ch2_count,
    input wire logic ch0_general_reg_c_event,
    input wire logic ch1_capture_compare_pin_b_in,
    output logic ch1_capture_compare_pin_b_out,
    output logic ch1_capture_compare_pin_b_oe,
    input wire logic ch2_capture_compare_pin_b_in,
    output logic ch2_capture_compare_pin_b_out,
    output logic ch2_capture_compare_pin_b_oe,
    output logic irq
);
    import tpc_pkg::*;

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (CNT_W < 1 || CNT_W > DATA_W) begin : g_bad_width
        $error("CNT_W must lie between 1 and the data width");
    end

    // ****************************************
    // Registers and nets
    // ****************************************
    logic [CTRL_W-1:0] timer_io_control_ch1;
    logic [CTRL_W-1:0] timer_io_control_ch2;
    logic [CNT_W-1:0] ch1_general_reg_b;
    logic [CNT_W-1:0] ch2_general_reg_b;
    logic [EVT_W-1:0] irq_status;
    logic [EVT_W-1:0] irq_mask;
    logic [EVT_W-1:0] events;
    logic [1:0] pins_sync;
    logic wr_ctrl1;
    logic wr_ctrl2;
    logic wr_gen1;
    logic wr_gen2;
    logic wr_status;
    logic wr_mask;
    logic [DATA_W-1:0] next_rdata;

    tpc_chan_if #(.CNT_W(CNT_W)) ch1 ();
    tpc_chan_if #(.CNT_W(CNT_W)) ch2 ();

    // ****************************************
    // Pin synchronisers
    // ****************************************
    tpc_sync #(.W(2)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d({ch2_capture_compare_pin_b_in, ch1_capture_compare_pin_b_in}),
        .q(pins_sync)
    );

    // ****************************************
    // Write decode
    // ****************************************
    always_comb begin
        wr_ctrl1 = 1'b0;
        wr_ctrl2 = 1'b0;
        wr_gen1 = 1'b0;
        wr_gen2 = 1'b0;
        wr_status = 1'b0;
        wr_mask = 1'b0;
        if (!wr) begin
            wr_ctrl1 = 1'b0;
        end else if (addr == OFS_IO_CTRL_CH1) begin
            wr_ctrl1 = 1'b1;
        end else if (addr == OFS_IO_CTRL_CH2) begin
            wr_ctrl2 = 1'b1;
        end else if (addr == OFS_GEN_B_CH1) begin
            wr_gen1 = 1'b1;
        end else if (addr == OFS_GEN_B_CH2) begin
            wr_gen2 = 1'b1;
        end else if (addr == OFS_IRQ_STATUS) begin
            wr_status = 1'b1;
        end else if (addr == OFS_IRQ_MASK) begin
            wr_mask = 1'b1;
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timer_io_control_ch1 <= IO_CTRL_RESET;
        end else if (wr_ctrl1) begin
            timer_io_control_ch1 <= wdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timer_io_control_ch2 <= IO_CTRL_RESET;
        end else if (wr_ctrl2) begin
            timer_io_control_ch2 <= wdata[CTRL_W-1:0];
        end
    end

    // Field write strobes follow the write so the channel sees the new code
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ch1.field_wr <= 1'b0;
            ch2.field_wr <= 1'b0;
        end else begin
            ch1.field_wr <= wr_ctrl1;
            ch2.field_wr <= wr_ctrl2;
        end
    end

    // ****************************************
    // General registers B
    // ****************************************
    // Capture wins over a software write in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ch1_general_reg_b <= '0;
        end else if (ch1.capture) begin
            ch1_general_reg_b <= ch1_count;
        end else if (wr_gen1) begin
            ch1_general_reg_b <= wdata[CNT_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ch2_general_reg_b <= '0;
        end else if (ch2.capture) begin
            ch2_general_reg_b <= ch2_count;
        end else if (wr_gen2) begin
            ch2_general_reg_b <= wdata[CNT_W-1:0];
        end
    end

    // ****************************************
    // Channel wiring
    // ****************************************
    assign ch1.field = timer_io_control_ch1[FIELD_LSB +: FIELD_W];
    assign ch1.gen_b = ch1_general_reg_b;
    assign ch1.count = ch1_count;
    assign ch1.pin_in = pins_sync[0];
    assign ch1.trig = ch0_general_reg_c_event;

    assign ch2.field = timer_io_control_ch2[FIELD_LSB +: FIELD_W];
    assign ch2.gen_b = ch2_general_reg_b;
    assign ch2.count = ch2_count;
    assign ch2.pin_in = pins_sync[1];
    assign ch2.trig = 1'b0;

    tpc_chan #(.IS_CH1(1'b1)) u_ch1 (
        .clock(clock),
        .rst_n(rst_n),
        .ch(ch1.chan)
    );

    tpc_chan #(.IS_CH1(1'b0)) u_ch2 (
        .clock(clock),
        .rst_n(rst_n),
        .ch(ch2.chan)
    );

    assign ch1_capture_compare_pin_b_out = ch1.pin_out;
    assign ch1_capture_compare_pin_b_oe = ch1.pin_oe;
    assign ch2_capture_compare_pin_b_out = ch2.pin_out;
    assign ch2_capture_compare_pin_b_oe = ch2.pin_oe;

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    always_comb begin
        events = '0;
        events[EVT_CH1_MATCH] = ch1.match;
        events[EVT_CH1_CAPTURE] = ch1.capture;
        events[EVT_CH2_MATCH] = ch2.match;
        events[EVT_CH2_CAPTURE] = ch2.capture;
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= IRQ_RESET;
        end else if (wr_status) begin
            irq_status <= (irq_status & ~wdata[EVT_W-1:0]) | events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= IRQ_RESET;
        end else if (wr_mask) begin
            irq_mask <= wdata[EVT_W-1:0];
        end
    end

    // Registered from the next status so it tracks the masked status bits exactly
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else if (wr_status) begin
            irq <= |(((irq_status & ~wdata[EVT_W-1:0]) | events) & irq_mask);
        end else if (wr_mask) begin
            irq <= |((irq_status | events) & wdata[EVT_W-1:0]);
        end else begin
            irq <= |((irq_status | events) & irq_mask);
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        next_rdata = '0;
        if (!rd) begin
            next_rdata = '0;
        end else if (addr == OFS_IO_CTRL_CH1) begin
            next_rdata[CTRL_W-1:0] = timer_io_control_ch1;
        end else if (addr == OFS_IO_CTRL_CH2) begin
            next_rdata[CTRL_W-1:0] = timer_io_control_ch2;
        end else if (addr == OFS_GEN_B_CH1) begin
            next_rdata[CNT_W-1:0] = ch1_general_reg_b;
        end else if (addr == OFS_GEN_B_CH2) begin
            next_rdata[CNT_W-1:0] = ch2_general_reg_b;
        end else if (addr == OFS_IRQ_STATUS) begin
            next_rdata[EVT_W-1:0] = irq_status;
        end else if (addr == OFS_IRQ_MASK) begin
            next_rdata[EVT_W-1:0] = irq_mask;
        end else if (addr == OFS_PIN_STATE) begin
            next_rdata[5:0] = {ch2.pin_oe, ch2.pin_out, pins_sync[1],
                               ch1.pin_oe, ch1.pin_out, pins_sync[0]};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule

// *** rtl/tpc_pkg.sv ***
// Package: register map, field layout and roles of the pin B control block
package tpc_pkg;

    // ****************************************
    // Bus and data widths
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CTRL_W = 8;
    localparam int CNT_W_DEF = 16;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_IO_CTRL_CH1 = 8'h00;
    localparam logic [7:0] OFS_IO_CTRL_CH2 = 8'h04;
    localparam logic [7:0] OFS_GEN_B_CH1 = 8'h08;
    localparam logic [7:0] OFS_GEN_B_CH2 = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_PIN_STATE = 8'h18;

    // ****************************************
    // Pin B field of the control register
    // ****************************************
    localparam int ROLE_SELECT_POS = 7;
    localparam int INITIAL_LEVEL_POS = 6;
    localparam int ACTION_HI_POS = 5;
    localparam int ACTION_LO_POS = 4;
    localparam int FIELD_LSB = 4;
    localparam int FIELD_W = 4;

    // ****************************************
    // Reset values and status layout
    // ****************************************
    localparam logic [7:0] IO_CTRL_RESET = 8'h00;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    localparam int EVT_W = 4;
    localparam int EVT_CH1_MATCH = 0;
    localparam int EVT_CH1_CAPTURE = 1;
    localparam int EVT_CH2_MATCH = 2;
    localparam int EVT_CH2_CAPTURE = 3;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0] {
        ROLE_OFF,
        ROLE_CMP_LOW,
        ROLE_CMP_HIGH,
        ROLE_CMP_TOGGLE,
        ROLE_CAP_RISE,
        ROLE_CAP_FALL,
        ROLE_CAP_BOTH,
        ROLE_CAP_TRIG
    } tpc_role_t;

    // Field to role; channel 2 ignores the initial level bit in capture
    function automatic tpc_role_t tpc_decode(input logic [3:0] f, input logic is_ch1);
        tpc_role_t r;
        r = ROLE_OFF;
        if (!f[3]) begin
            case (f[1:0])
                2'b01: r = ROLE_CMP_LOW;
                2'b10: r = ROLE_CMP_HIGH;
                2'b11: r = ROLE_CMP_TOGGLE;
                default: r = ROLE_OFF;
            endcase
        end else if (is_ch1 && f[2]) begin
            r = ROLE_CAP_TRIG;
        end else if (f[1]) begin
            r = ROLE_CAP_BOTH;
        end else if (f[0]) begin
            r = ROLE_CAP_FALL;
        end else begin
            r = ROLE_CAP_RISE;
        end
        return r;
    endfunction

endpackage

// *** rtl/tpc_chan_if.sv ***
// Interface between the register side and one pin B channel
`timescale 1ns/1ns
interface tpc_chan_if #(parameter int CNT_W = 16);
    logic [3:0] field;
    logic field_wr;
    logic [CNT_W-1:0] gen_b;
    logic [CNT_W-1:0] count;
    logic pin_in;
    logic trig;
    logic match;
    logic capture;
    logic pin_out;
    logic pin_oe;

    modport ctrl (
        output field, field_wr, gen_b, count, pin_in, trig,
        input match, capture, pin_out, pin_oe
    );
    modport chan (
        input field, field_wr, gen_b, count, pin_in, trig,
        output match, capture, pin_out, pin_oe
    );
endinterface

// *** rtl/tpc_sync.sv ***
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module tpc_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// *** rtl/tpc_chan.sv ***
// One channel: compare match pin action and capture event detection
`timescale 1ns/1ns
module tpc_chan #(
    parameter bit IS_CH1 = 1'b0
) (
    input wire logic clock,
    input wire logic rst_n,
    tpc_chan_if.chan ch
);
    import tpc_pkg::*;

    tpc_role_t role;
    logic is_cmp;
    logic equal;
    logic equal_d;
    logic pin_d;
    logic rise;
    logic fall;

    always_comb begin
        role = tpc_decode(ch.field, IS_CH1);
        is_cmp = (role == ROLE_CMP_LOW) || (role == ROLE_CMP_HIGH) ||
                 (role == ROLE_CMP_TOGGLE);
        equal = (ch.count == ch.gen_b);
        rise = ch.pin_in & ~pin_d;
        fall = ~ch.pin_in & pin_d;
    end

    // Match fires once when the counter arrives at the register value
    assign ch.match = is_cmp & equal & ~equal_d;

    assign ch.capture = (rise & (role == ROLE_CAP_RISE)) |
                        (fall & (role == ROLE_CAP_FALL)) |
                        ((rise | fall) & (role == ROLE_CAP_BOTH)) |
                        (ch.trig & (role == ROLE_CAP_TRIG));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            equal_d <= 1'b0;
            pin_d <= 1'b0;
        end else begin
            equal_d <= equal;
            pin_d <= ch.pin_in;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ch.pin_out <= 1'b0;
        end else if (ch.field_wr && is_cmp) begin
            ch.pin_out <= ch.field[INITIAL_LEVEL_POS-FIELD_LSB];
        end else if (ch.match) begin
            case (role)
                ROLE_CMP_LOW: ch.pin_out <= 1'b0;
                ROLE_CMP_HIGH: ch.pin_out <= 1'b1;
                ROLE_CMP_TOGGLE: ch.pin_out <= ~ch.pin_out;
                default: ch.pin_out <= ch.pin_out;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ch.pin_oe <= 1'b0;
        end else begin
            ch.pin_oe <= is_cmp;
        end
    end
endmodule

// *** bench/tpc_far_model.sv ***
// Far side model: timer counter and channel 0 register C event
`timescale 1ns/1ns
module tpc_far_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hold,
    input wire logic fire,
    output logic [15:0] count,
    output logic evt
);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            evt <= 1'b0;
        end else begin
            count <= hold ? count : count + 16'h0001;
            evt <= fire;
        end
    end
endmodule

// *** bench/tpc_top_checker.sv ***
// Checker: pin B roles, initial levels and trigger captures at the top ports
`timescale 1ns/1ns
module tpc_top_checker
    import tpc_pkg::*;
#(
    parameter int CNT_W = tpc_pkg::CNT_W_DEF
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [tpc_pkg::ADDR_W-1:0] addr,
    input wire logic [tpc_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [tpc_pkg::DATA_W-1:0] rdata,
    input wire logic [CNT_W-1:0] ch1_count,
    input wire logic [CNT_W-1:0] ch2_count,
    input wire logic ch0_general_reg_c_event,
    input wire logic ch1_capture_compare_pin_b_out,
    input wire logic ch1_capture_compare_pin_b_oe,
    input wire logic ch2_capture_compare_pin_b_out,
    input wire logic ch2_capture_compare_pin_b_oe
);
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [CNT_W-1:0] gb1;
    logic [CNT_W-1:0] gb2;
    logic gv1;
    logic gv2;
    logic pe1;
    logic pe2;
    logic wr_d;
    logic trig1;
    logic m1;
    logic m2;
    logic q1;
    logic q2;
    logic o1;
    logic o2;
    assign o1 = ch1_capture_compare_pin_b_out;
    assign o2 = ch2_capture_compare_pin_b_out;
    assign trig1 = ctl1[7] && ctl1[6] && ch0_general_reg_c_event;
    assign m1 = ch1_count == gb1 && !pe1;
    assign m2 = ch2_count == gb2 && !pe2;
    // Shadow only trusted in compare roles, no write last cycle
    assign q1 = gv1 && !wr_d && !ctl1[7];
    assign q2 = gv2 && !wr_d && !ctl2[7];

    // *****
    // Shadow registers
    // *****
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctl1 <= IO_CTRL_RESET;
            ctl2 <= IO_CTRL_RESET;
            wr_d <= 1'b0;
            pe1 <= 1'b0;
            pe2 <= 1'b0;
        end else begin
            wr_d <= wr;
            pe1 <= ch1_count == gb1;
            pe2 <= ch2_count == gb2;
            if (wr && addr == OFS_IO_CTRL_CH1) begin
                ctl1 <= wdata[7:0];
            end
            if (wr && addr == OFS_IO_CTRL_CH2) begin
                ctl2 <= wdata[7:0];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gb1 <= '0;
            gb2 <= '0;
            gv1 <= 1'b1;
            gv2 <= 1'b1;
        end else begin
            if (trig1) begin
                gb1 <= ch1_count;
                gv1 <= 1'b1;
            end else if (wr && addr == OFS_GEN_B_CH1) begin
                gb1 <= wdata[CNT_W-1:0];
                gv1 <= 1'b1;
            end else if (ctl1[7] && !ctl1[6]) begin
                gv1 <= 1'b0;
            end
            if (wr && addr == OFS_GEN_B_CH2) begin
                gb2 <= wdata[CNT_W-1:0];
                gv2 <= 1'b1;
            end else if (ctl2[7]) begin
                gv2 <= 1'b0;
            end
        end
    end

    // *****
    // Assertions
    // *****
    AST_CMP_LOW: assert property (q1 && m1 && ctl1[5:4] == 2'b01 |=> !o1)
        else $error("ch1 pin not low after match");
    AST_CMP_HIGH: assert property (q2 && m2 && ctl2[5:4] == 2'b10 |=> o2)
        else $error("ch2 pin not high after match");
    AST_CMP_TOGGLE: assert property (q1 && m1 && ctl1[5:4] == 2'b11 |=> o1 != $past(o1))
        else $error("ch1 pin did not toggle");
    AST_HOLD_CH2: assert property (q2 && !m2 && ctl2[5:4] != 2'b00 |=> $stable(o2))
        else $error("ch2 pin moved without match");
    AST_OE_CH1: assert property (
        !wr_d |-> ch1_capture_compare_pin_b_oe == (!ctl1[7] && ctl1[5:4] != 2'b00))
        else $error("ch1 enable wrong for role");
    AST_OE_CH2: assert property (
        !wr_d |-> ch2_capture_compare_pin_b_oe == (!ctl2[7] && ctl2[5:4] != 2'b00))
        else $error("ch2 enable wrong for role");
    AST_INIT_CH1: assert property (
        wr && addr == OFS_IO_CTRL_CH1 && !wdata[7] && wdata[5:4] != 2'b00
        |-> ##2 o1 == $past(wdata[6], 2))
        else $error("ch1 initial level wrong");
    AST_TRIG_READ: assert property (
        rd && addr == OFS_GEN_B_CH1 && gv1 |=> rdata == DATA_W'($past(gb1)))
        else $error("ch1 register B value wrong");

    cover property (q1 && m1 && ctl1[5:4] == 2'b11);
    cover property (trig1);
    cover property (q2 && m2);
endmodule

bind tpc_top tpc_top_checker #(.CNT_W(CNT_W)) tpc_top_checker_i (
    .clock, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .ch1_count, .ch2_count,
    .ch0_general_reg_c_event, .ch1_capture_compare_pin_b_out, .ch1_capture_compare_pin_b_oe,
    .ch2_capture_compare_pin_b_out, .ch2_capture_compare_pin_b_oe);

// *** bench/timer_ch1_ch2_pin_b_io_control_test.sv ***
// Testbench: pin B roles, register port and interrupt
`timescale 1ns/1ns
module timer_ch1_ch2_pin_b_io_control_test;
    import tpc_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic hold = 1'b1;
    logic fire = 1'b0;
    logic [1:0] pin = 2'b00;
    logic [31:0] rdata;
    logic [15:0] count;
    logic evt;
    logic irq;
    logic [1:0] po;
    logic [1:0] poe;
    int fails = 0;
    int total_checks = 0;

    initial begin
        forever #2 clock = ~clock;
    end

    tpc_far_model tpc_far_model_i (.clock(clock), .rst_n(rst_n), .hold(hold), .fire(fire),
        .count(count), .evt(evt));
    tpc_top tpc_top_i (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .ch1_count(count), .ch2_count(count),
        .ch0_general_reg_c_event(evt), .ch1_capture_compare_pin_b_in(pin[0]),
        .ch1_capture_compare_pin_b_out(po[0]), .ch1_capture_compare_pin_b_oe(poe[0]),
        .ch2_capture_compare_pin_b_in(pin[1]), .ch2_capture_compare_pin_b_out(po[1]),
        .ch2_capture_compare_pin_b_oe(poe[1]), .irq(irq));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        tick(1);
        wr <= 1'b0;
        tick(1);
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rd <= 1'b1;
        tick(1);
        rd <= 1'b0;
        @(negedge clock);
        v = rdata;
        tick(1);
    endtask

    task automatic t_reset();
        logic [31:0] v;
        @(negedge clock);
        check("pin enables", poe, 2'b00);
        tick(1);
        rd_reg(OFS_IO_CTRL_CH1, v);
        check("ctrl ch1", v, IO_CTRL_RESET);
        wr_reg(OFS_IO_CTRL_CH2, 32'h0000_00A5);
        rd_reg(OFS_IO_CTRL_CH2, v);
        check("ctrl ch2", v, 32'h0000_00A5);
        wr_reg(OFS_IO_CTRL_CH2, '0);
        rd_reg(8'h1C, v);
        check("unmapped", v, '0);
    endtask

    task automatic t_compare();
        logic [7:0] codes [8] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70};
        logic [7:0] c;
        logic on;
        logic x;
        wr_reg(OFS_IRQ_MASK, 32'h0000_0005);
        for (int ch = 0; ch < 2; ch++) begin
            foreach (codes[i]) begin
                c = codes[i];
                on = c[5:4] != 2'b00;
                x = (c[5:4] == 2'b11) ? !c[6] : c[5];
                wr_reg(OFS_GEN_B_CH1 + 8'(ch * 4), {16'h0000, count + 16'h0006});
                wr_reg(8'(ch * 4), {24'h00_0000, c});
                @(negedge clock);
                check("pin enable", poe[ch], on);
                if (on) check("initial level", po[ch], c[6]);
                tick(1);
                hold <= 1'b0;
                tick(10);
                hold <= 1'b1;
                @(negedge clock);
                if (on) check("level after match", po[ch], x);
                check("irq", irq, on);
                tick(1);
                wr_reg(OFS_IRQ_MASK, '0);
                @(negedge clock);
                check("irq masked", irq, '0);
                tick(1);
                wr_reg(OFS_IRQ_STATUS, 32'h0000_000F);
                wr_reg(OFS_IRQ_MASK, 32'h0000_0005);
            end
        end
    endtask

    task automatic t_capture();
        logic [10:0] tab [8] = '{{1'b0, 8'h80, 2'b10}, {1'b0, 8'h90, 2'b01},
            {1'b0, 8'hA0, 2'b11}, {1'b0, 8'hB0, 2'b11}, {1'b0, 8'hC0, 2'b00},
            {1'b1, 8'hC0, 2'b10}, {1'b1, 8'hD0, 2'b01}, {1'b1, 8'hE0, 2'b11}};
        logic ch;
        logic [7:0] c;
        logic [1:0] rf;
        logic [31:0] v;
        foreach (tab[i]) begin
            {ch, c, rf} = tab[i];
            wr_reg({5'h00, ch, 2'h0}, {24'h00_0000, c});
            for (int lvl = 1; lvl >= 0; lvl--) begin
                wr_reg(OFS_GEN_B_CH1 + {5'h00, ch, 2'h0}, '0);
                pin[ch] <= lvl[0];
                tick(5);
                rd_reg(OFS_GEN_B_CH1 + {5'h00, ch, 2'h0}, v);
                check("captured count", v, rf[lvl] ? {16'h0000, count} : '0);
            end
        end
    endtask

    task automatic t_trig();
        logic [15:0] k;
        logic [31:0] v;
        wr_reg(OFS_IRQ_STATUS, 32'h0000_000F);
        wr_reg(OFS_IO_CTRL_CH1, 32'h0000_00C0);
        hold <= 1'b0;
        fire <= 1'b1;
        tick(1);
        fire <= 1'b0;
        @(negedge clock);
        k = count;
        tick(1);
        hold <= 1'b1;
        tick(1);
        rd_reg(OFS_GEN_B_CH1, v);
        check("trigger capture", v, {16'h0000, k});
        rd_reg(OFS_IRQ_STATUS, v);
        check("capture status", v, 32'h0000_0002);
    endtask

    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        tick(1);
        t_reset();
        t_compare();
        t_capture();
        t_trig();
        tally_and_finish();
    end

    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end
endmodule
